// >>> core/tv_sync_pkg.sv
// Purpose: constants and carrier types of the TV sync timing generator
// Assumes: sys_clk is the master clock, one edge per master period
// Notes: tap pairs are (long line, short line) ring positions
package tv_sync_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Master clock figures per line-rate select setting
  localparam int MCLK_HI_HZ = 2045450;
  localparam int MCLK_LO_HZ = 1260000;
  localparam int RESTART_QUANT_NS = 500;

  // Horizontal ring lengths
  localparam int H_LEN_HI = 65;
  localparam int H_LEN_LO = 40;

  ////////////////////////////////////////////////////////////////////////
  // Horizontal taps, position 0 is the sync leading edge
  localparam int T_HALF_HI = 32;
  localparam int T_HALF_LO = 20;
  localparam int T_SYNC_END_HI = 10;
  localparam int T_SYNC_END_LO = 6;
  localparam int T_EQ_END_HI = 5;
  localparam int T_EQ_END_LO = 3;
  localparam int T_EQ_MID_END_HI = 37;
  localparam int T_EQ_MID_END_LO = 23;
  localparam int T_SER_END_A_HI = 22;
  localparam int T_SER_END_A_LO = 14;
  localparam int T_SER_END_B_HI = 55;
  localparam int T_SER_END_B_LO = 34;
  localparam int T_BURST_ON_HI = 12;
  localparam int T_BURST_ON_LO = 7;
  localparam int T_BURST_OFF_HI = 17;
  localparam int T_BURST_OFF_LO = 10;
  localparam int T_BLANK_ON_HI = 62;
  localparam int T_BLANK_ON_LO = 38;
  localparam int T_BLANK_END_HI = 22;
  localparam int T_BLANK_END_LO = 14;
  localparam int T_HDRV_END_HI = 7;
  localparam int T_HDRV_END_LO = 4;

  ////////////////////////////////////////////////////////////////////////
  // Vertical divider and timing register
  localparam int V_CNT_W = 10;
  localparam logic [9:0] V_MODULUS = 10'h20D;
  localparam logic [9:0] V_LOAD_ZERO = 10'h000;
  localparam logic [9:0] V_LOAD_ALT = 10'h00B;
  localparam int V_SR_LEN = 42;
  localparam int V_TAP_SERR = 5;
  localparam int V_TAP_EQ2 = 11;
  localparam int V_TAP_END = 17;
  localparam int V_TAP_BLANK = 41;
  localparam logic [41:0] V_SR_ONES = {42{1'b1}};
  localparam logic [41:0] V_SR_ALT = {{31{1'b1}}, 11'h000};

  // Field marker length in master clocks
  localparam logic [1:0] FIELD_MARK_LEN = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Composite sync separator
  localparam logic [4:0] SEP_BROAD_LEN = 5'h10;
  localparam logic [4:0] SEP_IDLE_LEN = 5'h18;
  localparam logic [2:0] SEP_SERR_NUM = 3'h5;

  // Timing outputs, all active high
  typedef struct packed {
    logic hDrive;
    logic vDrive;
    logic compBlank;
    logic compSync;
    logic burstGate;
    logic burstSync;
    logic fieldMark;
  } syncOut_s;

endpackage

// >>> core/sync_shift_reg.sv
// Purpose: loadable shift register for the dividers
// Assumes: synchronous active-low reset
// Notes: each cell resets or loads to a one or a zero
`timescale 1ns/1ps
module sync_shift_reg #(
  parameter int LEN = 8,
  parameter logic [LEN-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic shiftEn,
  input wire logic loadEn,
  input wire logic [LEN-1:0] loadVal,
  input wire logic serIn,
  output logic [LEN-1:0] q
);

  ////////////////////////////////////////////////////////////////////////
  // Load wins over shift so a restart is never half applied
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= RST_VAL; // [RULE8]
    end else if (loadEn) begin
      q <= loadVal; // [RULE8]
    end else if (shiftEn) begin
      q <= {q[LEN-2:0], serIn};
    end
  end

endmodule

// >>> core/tv_sync_gen.sv
// Purpose: 525-line interlaced sync timing generator
// Assumes: sys_clk is the master clock; inputs synchronous to it
// Notes: tap set and ring length follow lineSel, tie it static
//
// Function
// [RULE1] Select high expects 2.04545 MHz master clock
// [RULE2] Select low expects 1.260 MHz master clock
// [RULE3] Horizontal ring 65 stages, or 40
// [RULE4] Line select picks matching horizontal tap set
// [RULE5] Half-line tick drives vertical counter and register
// [RULE6] Vertical counter wraps modulo 525 half-lines
// [RULE7] Counter clearable; stages 1,2,8 forceable high
// [RULE8] Shift cells reset to one or zero
// [RULE9] All outputs derive from master clock only
// [RULE10] Burst sync is burst gate every other line
// [RULE11] Field marker identifies field one
// [RULE12] Composite sync on control pin restarts vertical
// [RULE13] Source sends short pulses on vertical restart
// [RULE14] Restarts act only on master clock edges
// [RULE15] Alternate restart loads eleventh half-line position
// [RULE16] Separator lock lags source by one frame; the code restarts on the fifth broad pulse of the same run
// [RULE17] Horizontal restart aligns within one master clock
// [RULE18] Raster is 525 lines, 60 Hz, interlaced
// [RULE19] Interval: equalize, serrate, equalize, drive, blank
// [RULE20] Field marker two clocks at field-one blank
// [RULE21] Control high clears, low loads eleven
// [RULE22] Each restart input resets only its divider
// [RULE23] Every output registered on master clock
`timescale 1ns/1ps
module tv_sync_gen (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic lineSel,
  input wire logic hRestart_n,
  input wire logic vRestart_n,
  input wire logic restartCtl,
  output tv_sync_pkg::syncOut_s syncOut_ff,
  output logic [9:0] vCount_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Signals
  logic [tv_sync_pkg::H_LEN_HI-1:0] hq;
  logic [tv_sync_pkg::V_SR_LEN-1:0] vq;
  logic [tv_sync_pkg::V_SR_LEN-1:0] vLoadVal;
  logic hRestartPrev_ff;
  logic vRestartPrev_ff;
  logic hRestartHit;
  logic vRestartHit;
  logic hRingIn;
  logic halfTick;
  logic lineTick;
  logic [9:0] nxt_vCount;
  logic vWrap;
  logic vLoad;
  logic [9:0] vLoadCnt;
  logic vInt_ff;
  logic fieldOne_ff;
  logic [1:0] markCnt_ff;
  logic lineOdd_ff;
  logic hSync_ff;
  logic hBlank_ff;
  logic hDrv_ff;
  logic burst_ff;
  logic eqZone;
  logic serZone;
  logic drvZone;
  logic [4:0] lowCnt_ff;
  logic [4:0] highCnt_ff;
  logic [2:0] broadCnt_ff;
  logic broadHit;
  logic sepRestart;
  logic syncOn;
  logic syncOff;

  // Tap chosen by line-rate select
  function automatic logic tapHit(
    input logic [tv_sync_pkg::H_LEN_HI-1:0] q,
    input logic sel,
    input int hi,
    input int lo
  );
    tapHit = sel ? q[hi] : q[lo];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Restart edge detection, sampled on master clock edges only
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hRestartPrev_ff <= 1'b1;
      vRestartPrev_ff <= 1'b1;
    end else begin
      hRestartPrev_ff <= hRestart_n; // [RULE14]
      vRestartPrev_ff <= vRestart_n; // [RULE14]
    end
  end

  // Pulse shape on the pin is the source's job
  assign hRestartHit = hRestartPrev_ff & ~hRestart_n; // [RULE22]
  assign vRestartHit = vRestartPrev_ff & ~vRestart_n; // [RULE13] [RULE22]

  ////////////////////////////////////////////////////////////////////////
  // Horizontal one-hot ring, shortened in low-rate mode
  assign hRingIn = lineSel ? hq[tv_sync_pkg::H_LEN_HI-1]
                           : hq[tv_sync_pkg::H_LEN_LO-1]; // [RULE3]

  // Unused upper stages in short mode may hold stale ones
  sync_shift_reg #(
    .LEN(tv_sync_pkg::H_LEN_HI),
    .RST_VAL({{(tv_sync_pkg::H_LEN_HI-1){1'b0}}, 1'b1})
  ) u_hring (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .shiftEn(1'b1),
    .loadEn(hRestartHit), // [RULE17]
    .loadVal({{(tv_sync_pkg::H_LEN_HI-1){1'b0}}, 1'b1}),
    .serIn(hRingIn),
    .q(hq)
  ); // [RULE1] [RULE2] [RULE9]

  assign lineTick = hq[0];
  assign halfTick = hq[0] | tapHit(hq, lineSel, tv_sync_pkg::T_HALF_HI,
                                   tv_sync_pkg::T_HALF_LO); // [RULE5]

  ////////////////////////////////////////////////////////////////////////
  // Composite sync separator on the restart-control pin
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lowCnt_ff <= 5'h00;
    end else if (restartCtl) begin
      lowCnt_ff <= 5'h00;
    end else if (lowCnt_ff != tv_sync_pkg::SEP_BROAD_LEN) begin
      lowCnt_ff <= lowCnt_ff + 5'h01;
    end
  end

  // Long gaps between pulses end a serration run
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      highCnt_ff <= 5'h00;
    end else if (!restartCtl) begin
      highCnt_ff <= 5'h00;
    end else if (highCnt_ff != tv_sync_pkg::SEP_IDLE_LEN) begin
      highCnt_ff <= highCnt_ff + 5'h01;
    end
  end

  assign broadHit = ~restartCtl &&
    (lowCnt_ff == tv_sync_pkg::SEP_BROAD_LEN - 5'h01); // [RULE12]

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      broadCnt_ff <= 3'h0;
    end else if (highCnt_ff == tv_sync_pkg::SEP_IDLE_LEN) begin
      broadCnt_ff <= 3'h0;
    end else if (broadHit && broadCnt_ff != tv_sync_pkg::SEP_SERR_NUM) begin
      broadCnt_ff <= broadCnt_ff + 3'h1; // [RULE12]
    end
  end

  // Fifth broad pulse: restart lands on the next master clock edge
  assign sepRestart = broadHit &&
    (broadCnt_ff == tv_sync_pkg::SEP_SERR_NUM - 3'h1); // [RULE12] [RULE16]

  ////////////////////////////////////////////////////////////////////////
  // Vertical restart selection
  always_comb begin
    vLoad = 1'b0;
    vLoadCnt = tv_sync_pkg::V_LOAD_ZERO;
    vLoadVal = tv_sync_pkg::V_SR_ONES;
    if (sepRestart) begin
      vLoad = 1'b1;
      vLoadCnt = tv_sync_pkg::V_LOAD_ALT; // [RULE12]
      vLoadVal = tv_sync_pkg::V_SR_ALT;
    end else if (vRestartHit) begin
      vLoad = 1'b1;
      if (restartCtl) begin
        vLoadCnt = tv_sync_pkg::V_LOAD_ZERO; // [RULE21]
        vLoadVal = tv_sync_pkg::V_SR_ONES;
      end else begin
        vLoadCnt = tv_sync_pkg::V_LOAD_ALT; // [RULE15] [RULE21]
        vLoadVal = tv_sync_pkg::V_SR_ALT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vertical counter, modulo 525 half-lines
  always_comb begin
    nxt_vCount = vCount_ff + 10'h001;
    vWrap = 1'b0;
    if (nxt_vCount == tv_sync_pkg::V_MODULUS) begin
      nxt_vCount = 10'h000; // [RULE6]
      vWrap = halfTick;
    end
  end

  // Restart loads every stage on one edge: all clear, or with the set ones forced
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      vCount_ff <= 10'h000;
    end else if (vLoad) begin
      vCount_ff <= vLoadCnt; // [RULE7]
    end else if (halfTick) begin
      vCount_ff <= nxt_vCount; // [RULE5] [RULE18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vertical timing register; a zero train marks the interval
  sync_shift_reg #(
    .LEN(tv_sync_pkg::V_SR_LEN),
    .RST_VAL(tv_sync_pkg::V_SR_ONES)
  ) u_vreg (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .shiftEn(halfTick), // [RULE5]
    .loadEn(vLoad),
    .loadVal(vLoadVal),
    .serIn(~vInt_ff),
    .q(vq)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      vInt_ff <= 1'b0;
    end else if (vLoad || vWrap) begin
      vInt_ff <= 1'b1; // [RULE19]
    end else if (vInt_ff && !vq[tv_sync_pkg::V_TAP_BLANK]) begin
      vInt_ff <= 1'b0; // [RULE19]
    end
  end

  assign eqZone = vInt_ff &
    ((vq[tv_sync_pkg::V_TAP_SERR]) |
     (~vq[tv_sync_pkg::V_TAP_EQ2] & vq[tv_sync_pkg::V_TAP_END])); // [RULE19]
  assign serZone = vInt_ff & ~vq[tv_sync_pkg::V_TAP_SERR] &
    vq[tv_sync_pkg::V_TAP_EQ2]; // [RULE19]
  assign drvZone = vInt_ff & vq[tv_sync_pkg::V_TAP_END]; // [RULE19]

  ////////////////////////////////////////////////////////////////////////
  // Field tracking and marker
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fieldOne_ff <= 1'b0;
    end else if (vLoad && vLoadCnt == tv_sync_pkg::V_LOAD_ZERO) begin
      fieldOne_ff <= 1'b1;
    end else if (vWrap) begin
      fieldOne_ff <= ~fieldOne_ff; // [RULE11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      markCnt_ff <= 2'h0;
    end else if (vLoad && vLoadCnt == tv_sync_pkg::V_LOAD_ZERO) begin
      markCnt_ff <= tv_sync_pkg::FIELD_MARK_LEN; // [RULE20]
    end else if (vWrap && !fieldOne_ff) begin
      markCnt_ff <= tv_sync_pkg::FIELD_MARK_LEN; // [RULE20]
    end else if (markCnt_ff != 2'h0) begin
      markCnt_ff <= markCnt_ff - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Horizontal edges from the selected tap set
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hBlank_ff <= 1'b0;
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_BLANK_ON_HI,
                        tv_sync_pkg::T_BLANK_ON_LO)) begin
      hBlank_ff <= 1'b1; // [RULE4]
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_BLANK_END_HI,
                        tv_sync_pkg::T_BLANK_END_LO)) begin
      hBlank_ff <= 1'b0; // [RULE4]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hDrv_ff <= 1'b0;
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_BLANK_ON_HI,
                        tv_sync_pkg::T_BLANK_ON_LO)) begin
      hDrv_ff <= 1'b1; // [RULE4]
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_HDRV_END_HI,
                        tv_sync_pkg::T_HDRV_END_LO)) begin
      hDrv_ff <= 1'b0; // [RULE4]
    end
  end

  // Burst is left out across vertical drive
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      burst_ff <= 1'b0;
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_BURST_ON_HI,
                        tv_sync_pkg::T_BURST_ON_LO)) begin
      burst_ff <= ~drvZone; // [RULE4]
    end else if (tapHit(hq, lineSel, tv_sync_pkg::T_BURST_OFF_HI,
                        tv_sync_pkg::T_BURST_OFF_LO)) begin
      burst_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lineOdd_ff <= 1'b0;
    end else if (lineTick) begin
      lineOdd_ff <= ~lineOdd_ff; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Composite sync: line sync, equalizing or serrated per zone
  always_comb begin
    syncOn = lineTick | ((eqZone | serZone) & halfTick);
    if (serZone) begin
      syncOff = tapHit(hq, lineSel, tv_sync_pkg::T_SER_END_A_HI,
                       tv_sync_pkg::T_SER_END_A_LO) |
                tapHit(hq, lineSel, tv_sync_pkg::T_SER_END_B_HI,
                       tv_sync_pkg::T_SER_END_B_LO); // [RULE19]
    end else if (eqZone) begin
      syncOff = tapHit(hq, lineSel, tv_sync_pkg::T_EQ_END_HI,
                       tv_sync_pkg::T_EQ_END_LO) |
                tapHit(hq, lineSel, tv_sync_pkg::T_EQ_MID_END_HI,
                       tv_sync_pkg::T_EQ_MID_END_LO); // [RULE19]
    end else begin
      syncOff = tapHit(hq, lineSel, tv_sync_pkg::T_SYNC_END_HI,
                       tv_sync_pkg::T_SYNC_END_LO); // [RULE4]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hSync_ff <= 1'b0;
    end else if (syncOn) begin
      hSync_ff <= 1'b1;
    end else if (syncOff) begin
      hSync_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output retiming so every edge lands on a master clock edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      syncOut_ff <= '0;
    end else begin
      syncOut_ff.hDrive <= hDrv_ff; // [RULE23] [RULE9]
      syncOut_ff.vDrive <= drvZone; // [RULE23]
      syncOut_ff.compBlank <= hBlank_ff | vInt_ff; // [RULE23]
      syncOut_ff.compSync <= hSync_ff; // [RULE23]
      syncOut_ff.burstGate <= burst_ff & ~drvZone; // [RULE23] [RULE19]
      syncOut_ff.burstSync <= burst_ff & lineOdd_ff & ~drvZone; // [RULE10]
      syncOut_ff.fieldMark <= (markCnt_ff != 2'h0); // [RULE11] [RULE20]
    end
  end

endmodule

// >>> tb/tv_sync_gen_sva.sv
// Purpose: port-level checks of the TV sync timing generator
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every tv_sync_gen instance
`timescale 1ns/1ps
module tv_sync_gen_sva (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic lineSel,
  input wire logic hRestart_n,
  input wire logic vRestart_n,
  input wire logic restartCtl,
  input wire tv_sync_pkg::syncOut_s syncOut_ff,
  input wire logic [9:0] vCount_ff
);
  logic [7:0] hQuiet;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  //////////////////////////////////////////////////////////////////////////
  // Clocks since the ring was last forced to position 0
  always_ff @(posedge sys_clk) begin
    if (!rst_b || $fell(hRestart_n)) begin
      hQuiet <= 8'h00;
    end else if (hQuiet != 8'hFF) begin
      hQuiet <= hQuiet + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_vcount_range: assert property (
    vCount_ff <= 10'h20C)
    else $error("vertical count out of range");
  a_vcount_step: assert property (
    $changed(vCount_ff) |-> vCount_ff == $past(vCount_ff) + 10'h001
    || vCount_ff == 10'h000 || vCount_ff == 10'h00B)
    else $error("vertical count jumped");
  a_vrestart_clear: assert property (
    $fell(vRestart_n) && restartCtl && $past(restartCtl)
    |=> vCount_ff == 10'h000)
    else $error("vertical restart did not clear");
  a_vrestart_alt: assert property (
    $fell(vRestart_n) && !restartCtl |=> vCount_ff == 10'h00B)
    else $error("alternate restart did not load eleven");
  a_mark_two_clk: assert property (
    $rose(syncOut_ff.fieldMark)
    |=> syncOut_ff.fieldMark ##1 !syncOut_ff.fieldMark)
    else $error("field marker width wrong");
  a_mark_in_blank: assert property (
    syncOut_ff.fieldMark |-> syncOut_ff.compBlank)
    else $error("field marker outside blanking");
  a_hrestart_sync: assert property (
    $fell(hRestart_n) |-> ##[2:3] syncOut_ff.compSync)
    else $error("sync late after horizontal restart");
  a_burst_half: assert property (
    syncOut_ff.burstSync |-> syncOut_ff.burstGate)
    else $error("burst sync outside burst gate");
  a_drive_blank: assert property (
    syncOut_ff.hDrive || syncOut_ff.vDrive |-> syncOut_ff.compBlank)
    else $error("drive outside blanking");
  a_no_burst_vd: assert property (
    syncOut_ff.vDrive |-> !syncOut_ff.burstGate)
    else $error("burst during vertical drive");
  a_line_hi: assert property (
    lineSel && $rose(syncOut_ff.hDrive) && hQuiet > 8'h04
    |-> ##65 ($rose(syncOut_ff.hDrive) || hQuiet < 8'h42))
    else $error("line period wrong in long mode");
  a_line_lo: assert property (
    !lineSel && $rose(syncOut_ff.hDrive) && hQuiet > 8'h04
    |-> ##40 ($rose(syncOut_ff.hDrive) || hQuiet < 8'h29))
    else $error("line period wrong in short mode");
endmodule

bind tv_sync_gen tv_sync_gen_sva chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .lineSel(lineSel),
  .hRestart_n(hRestart_n),
  .vRestart_n(vRestart_n),
  .restartCtl(restartCtl),
  .syncOut_ff(syncOut_ff),
  .vCount_ff(vCount_ff)
);

// >>> tb/tv_sync_source.sv
// Purpose: external sync source driving the restart inputs
// Assumes: shares the master clock with the generator
// Notes: vertical and horizontal pulses are short, as from a differentiator
`timescale 1ns/1ps
module tv_sync_source (
  input wire logic sys_clk,
  output logic vRestart_n,
  output logic hRestart_n,
  output logic restartCtl
);
  initial begin
    vRestart_n = 1'b1;
    hRestart_n = 1'b1;
    restartCtl = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Short vertical pulse, control level held across it
  task automatic pulse_v(input logic lvl);
    @(posedge sys_clk);
    vRestart_n <= 1'b0;
    restartCtl <= lvl;
    repeat (3) @(posedge sys_clk);
    vRestart_n <= 1'b1;
    restartCtl <= 1'b1;
  endtask

  task automatic pulse_h();
    @(posedge sys_clk);
    hRestart_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    hRestart_n <= 1'b1;
  endtask

  // Gaps kept short so the broad pulses count as one run
  task automatic broad(input int num);
    repeat (num) begin
      @(posedge sys_clk);
      restartCtl <= 1'b0;
      repeat (20) @(posedge sys_clk);
      restartCtl <= 1'b1;
      repeat (7) @(posedge sys_clk);
    end
  endtask
endmodule

// >>> tb/tb_tv_sync_gen.sv
// Purpose: self-checking bench of the TV sync timing generator
// Assumes: sys_clk stands for the master clock
// Notes: short mode runs a full frame to see the field marker
`timescale 1ns/1ps
module tb_tv_sync_gen;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic lineSel = 1'b1;
  logic vRestart_n;
  logic hRestart_n;
  logic restartCtl;
  tv_sync_pkg::syncOut_s syncOut;
  tv_sync_pkg::syncOut_s pOut;
  logic [9:0] vCount;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int fmRise = 0;
  int fmHigh = 0;
  int gRise = 0;
  int sRise = 0;
  int cRise = 0;

  always #10 sys_clk = ~sys_clk;

  tv_sync_gen dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .lineSel(lineSel),
    .hRestart_n(hRestart_n),
    .vRestart_n(vRestart_n),
    .restartCtl(restartCtl),
    .syncOut_ff(syncOut),
    .vCount_ff(vCount)
  );

  tv_sync_source src (
    .sys_clk(sys_clk),
    .vRestart_n(vRestart_n),
    .hRestart_n(hRestart_n),
    .restartCtl(restartCtl)
  );

  //////////////////////////////////////////////////////////////////////////
  // Edge counters, read only between clock edges
  always @(posedge sys_clk) begin
    cyc++;
    if (syncOut.fieldMark === 1'b1) begin
      fmHigh++;
      if (pOut.fieldMark === 1'b0) begin
        fmRise++;
      end
    end
    if (syncOut.burstGate === 1'b1 && pOut.burstGate === 1'b0) begin
      gRise++;
    end
    if (syncOut.burstSync === 1'b1 && pOut.burstSync === 1'b0) begin
      sRise++;
    end
    if (syncOut.compSync === 1'b1 && pOut.compSync === 1'b0) begin
      cRise++;
    end
    pOut = syncOut;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // A half-line tick may land inside the restart pulse
  function automatic logic near(input logic [9:0] v, input logic [9:0] lo);
    return (v === lo) || (v === lo + 10'h001);
  endfunction

  task automatic do_reset(input logic sel);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    lineSel <= sel;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk_val({25'h0, syncOut}, 32'h0);
    chk_val({22'h0, vCount}, 32'h0);
    tick(1);
  endtask

  task automatic wait_hd(output int k);
    logic p;
    p = syncOut.hDrive;
    k = 0;
    repeat (100) begin
      tick(1);
      k++;
      if (syncOut.hDrive === 1'b1 && p === 1'b0) begin
        return;
      end
      p = syncOut.hDrive;
    end
    errors++;
    close_out();
  endtask

  task automatic wait_vc(input logic [9:0] v);
    repeat (12000) begin
      if (vCount === v) begin
        tick(3);
        return;
      end
      tick(1);
    end
    errors++;
    close_out();
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    int r0;
    logic [9:0] v;
    do_reset(1'b1);
    wait_hd(k);
    wait_hd(k);
    chk_val(k, 65);
    r0 = cyc;
    fmRise = 0;
    fmHigh = 0;
    src.pulse_v(1'b1);
    tick(1);
    chk_flag(near(vCount, 10'h000), 1'b1);
    chk_val(fmRise, 1);
    chk_val(fmHigh, 2);
    wait_hd(k);
    chk_val((cyc - r0) % 65, 0);
    src.pulse_v(1'b0);
    tick(1);
    chk_flag(near(vCount, 10'h00B), 1'b1);
    wait_vc(10'h03C);
    gRise = 0;
    sRise = 0;
    cRise = 0;
    tick(260);
    chk_val(gRise, 4);
    chk_val(sRise, 2);
    chk_val(cRise, 4);
    v = vCount;
    src.pulse_h();
    tick(1);
    chk_flag(vCount >= v && vCount <= v + 10'h002, 1'b1);
    wait_hd(k);
    wait_hd(k);
    chk_val(k, 65);
    src.broad(5);
    tick(1);
    chk_flag(near(vCount, 10'h00B), 1'b1);
    do_reset(1'b0);
    wait_hd(k);
    wait_hd(k);
    chk_val(k, 40);
    fmRise = 0;
    src.pulse_v(1'b1);
    wait_vc(10'h005);
    chk_flag(syncOut.vDrive, 1'b1);
    chk_flag(syncOut.compBlank, 1'b1);
    // Two pulses a line inside the interval
    cRise = 0;
    tick(40);
    chk_val(cRise, 2);
    wait_vc(10'h014);
    chk_flag(syncOut.vDrive, 1'b0);
    wait_vc(10'h20C);
    r0 = cyc;
    wait_vc(10'h000);
    chk_flag(cyc - r0 <= 25, 1'b1);
    chk_val(fmRise, 1);
    wait_vc(10'h20C);
    wait_vc(10'h000);
    chk_val(fmRise, 2);
    close_out();
  end
endmodule
